// File: logic/sfs_pkg.sv
/*
  Shared constants for the switching frequency, synchronization and shutdown block:
  register offsets, field positions, reset values, the strap frequency table and timing.
  Assumes a 20 MHz APB clock; frequencies are held in kHz and converted to switching periods in clock cycles.
*/
package sfs_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned PER_W = 8;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FREQ = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h010;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h014;
  localparam logic [11:0] ADDR_PERIOD = 12'h018;
  localparam int unsigned CTRL_OFF_BIT = 0;
  localparam int unsigned CTRL_OPEN_BIT = 1;
  localparam int unsigned EV_SYNC_ON = 0;
  localparam int unsigned EV_SYNC_OFF = 1;
  localparam int unsigned EV_SYNC_FAIL = 2;
  localparam int unsigned EV_SHUT = 3;
  localparam int unsigned EV_W = 4;
  localparam logic [10:0] FREQ_DEF_KHZ = 11'd607;
  localparam logic [10:0] FREQ_MIN_KHZ = 11'd166;
  localparam logic [10:0] FREQ_MAX_KHZ = 11'd1500;
  localparam int unsigned ADC_W = 10;
  localparam int unsigned LOSS_PERIODS = 4;
  localparam logic [PER_W-1:0] STEP_CYC = 8'd1;
  typedef enum logic [1:0] {SFS_INIT = 2'b00, SFS_FREE = 2'b01, SFS_SYNC = 2'b11,
                            SFS_FAIL = 2'b10} sfs_state_e;

  // Strap code 0..15 to frequency in kHz, ascending.
  function automatic logic [10:0] sfs_strap_khz(input logic [3:0] code);
    case (code)
      4'h0: sfs_strap_khz = 11'd306;
      4'h1: sfs_strap_khz = 11'd356;
      4'h2: sfs_strap_khz = 11'd400;
      4'h3: sfs_strap_khz = 11'd444;
      4'h4: sfs_strap_khz = 11'd500;
      4'h5: sfs_strap_khz = 11'd550;
      4'h6: sfs_strap_khz = 11'd600;
      4'h7: sfs_strap_khz = 11'd706;
      4'h8: sfs_strap_khz = 11'd750;
      4'h9: sfs_strap_khz = 11'd800;
      4'hA: sfs_strap_khz = 11'd923;
      4'hB: sfs_strap_khz = 11'd1000;
      4'hC: sfs_strap_khz = 11'd1091;
      4'hD: sfs_strap_khz = 11'd1200;
      4'hE: sfs_strap_khz = 11'd1333;
      default: sfs_strap_khz = 11'd1500;
    endcase
  endfunction : sfs_strap_khz

  // Frequency in kHz to switching period in clock cycles, rounded down.
  function automatic logic [PER_W-1:0] sfs_khz_to_per(input logic [10:0] khz);
    logic [31:0] q;
    q = (CLK_HZ / 1000) / ((khz == 11'd0) ? 32'd1 : {21'd0, khz});
    sfs_khz_to_per = (q > 32'd255) ? 8'hFF : q[PER_W-1:0];
  endfunction : sfs_khz_to_per
endpackage : sfs_pkg

// File: logic/sfs_top.sv
/*
  Switching frequency selection, external sync tracking and shutdown control with an
  APB register slave. Assumes strap, sync and enable comparator inputs synchronous to pclk,
  and a 10-bit converter result with a done strobe supplied during initialization.
*/
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module sfs_top
  import sfs_pkg::*;
#(
  parameter int unsigned LOSS_N = LOSS_PERIODS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic addr_strap_floating,
  input wire logic [ADC_W-1:0] rate_strap_adc,
  input wire logic rate_strap_adc_done,
  input wire logic rate_sync_pin,
  input wire logic enable_above_thr,
  output logic drv_high_on,
  output logic drv_low_on,
  output logic sw_clk,
  output logic [PER_W-1:0] ramp_slope,
  output logic irq
);
  sfs_state_e state_r;
  logic analog_r;
  logic sync_early_r;
  logic [10:0] free_khz_r;
  logic [10:0] freq_reg_r;
  logic [PER_W-1:0] per_r;
  logic [PER_W-1:0] cnt_r;
  logic [PER_W-1:0] ext_cnt_r;
  logic [PER_W-1:0] ext_per_r;
  logic [3:0] miss_r;
  logic sync_d_r;
  logic sync_seen_r;
  logic bus_off_r;
  logic bus_open_r;
  logic [EV_W-1:0] ist_r;
  logic [EV_W-1:0] ien_r;
  logic [EV_W-1:0] ev;
  logic run;
  logic run_d_r;
  logic wr;
  logic rd;
  logic clr_wr;
  logic sync_rise;
  logic wrap;
  logic [PER_W-1:0] free_per;
  logic [PER_W-1:0] target;
  logic [10:0] wr_khz;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign sync_rise = rate_sync_pin && !sync_d_r;
  assign wrap = (cnt_r >= per_r - STEP_CYC);
  assign free_per = sfs_khz_to_per(analog_r ? free_khz_r : freq_reg_r);
  assign target = (state_r == SFS_SYNC) ? ext_per_r : free_per;
  assign wr_khz = pwdata[10:0];
  assign clr_wr = wr && (paddr == ADDR_IRQ_CLR);

  // Power conversion runs only when enabled, not shut by bus, and not failed.
  assign run = enable_above_thr && !bus_off_r && (state_r != SFS_INIT)
               && (state_r != SFS_FAIL);
  assign drv_high_on = run && sw_clk;
  assign drv_low_on = run && !sw_clk;
  assign ramp_slope = per_r;

  // Mode and strap capture happen once; the strap is never looked at again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SFS_INIT;
      analog_r <= 1'b0;
      free_khz_r <= FREQ_DEF_KHZ;
      sync_early_r <= 1'b0;
    end else begin
      case (state_r)
        SFS_INIT: begin
          if (rate_strap_adc_done) begin
            analog_r <= addr_strap_floating;
            free_khz_r <= sfs_strap_khz(rate_strap_adc[ADC_W-1 -: 4]);
            sync_early_r <= sync_seen_r;
            state_r <= sync_seen_r ? SFS_SYNC : SFS_FREE;
          end
        end
        SFS_FREE: begin
          if (sync_rise) begin
            state_r <= SFS_SYNC;
          end
        end
        SFS_SYNC: begin
          if (miss_r >= 4'(LOSS_N)) begin
            state_r <= sync_early_r ? SFS_FAIL : SFS_FREE;
          end
        end
        default: begin
          state_r <= SFS_FAIL;
        end
      endcase
    end
  end

  // Sync edge detect, external period measure and loss counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d_r <= 1'b0;
      sync_seen_r <= 1'b0;
      ext_cnt_r <= 8'h00;
      ext_per_r <= 8'h01;
      miss_r <= 4'h0;
    end else begin
      sync_d_r <= rate_sync_pin;
      if (sync_rise) begin
        sync_seen_r <= 1'b1;
        ext_cnt_r <= 8'h01;
        if (ext_cnt_r != 8'h00) begin
          ext_per_r <= ext_cnt_r;
        end
        miss_r <= 4'h0;
      end else begin
        if (ext_cnt_r != 8'hFF) begin
          ext_cnt_r <= ext_cnt_r + 8'h01;
        end
        if (wrap && miss_r != 4'hF) begin
          miss_r <= miss_r + 4'h1;
        end
      end
    end
  end

  // Period walks toward target one bounded step per switching cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_r <= 8'd33;
      cnt_r <= 8'h00;
      sw_clk <= 1'b0;
    end else begin
      if (wrap) begin
        cnt_r <= 8'h00;
        if (per_r < target) begin
          per_r <= per_r + STEP_CYC;
        end else if (per_r > target && per_r > 8'd2) begin
          per_r <= per_r - STEP_CYC;
        end
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
      sw_clk <= (cnt_r < {1'b0, per_r[PER_W-1:1]});
    end
  end

  // Bus registers; frequency writes outside the legal range are ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_reg_r <= FREQ_DEF_KHZ;
      bus_off_r <= 1'b0;
      bus_open_r <= 1'b0;
      ien_r <= 4'h0;
    end else if (wr && !analog_r) begin
      if (paddr == ADDR_FREQ) begin
        if (wr_khz >= FREQ_MIN_KHZ && wr_khz <= FREQ_MAX_KHZ) begin
          freq_reg_r <= wr_khz;
        end
      end else if (paddr == ADDR_CTRL) begin
        bus_open_r <= pwdata[CTRL_OPEN_BIT];
        bus_off_r <= pwdata[CTRL_OFF_BIT] && pwdata[CTRL_OPEN_BIT];
      end else if (paddr == ADDR_IRQ_EN) begin
        ien_r <= pwdata[EV_W-1:0];
      end
    end
  end

  assign ev[EV_SYNC_ON] = (state_r == SFS_FREE) && sync_rise;
  assign ev[EV_SYNC_OFF] = (state_r == SFS_SYNC) && !sync_early_r && (miss_r >= 4'(LOSS_N));
  assign ev[EV_SYNC_FAIL] = (state_r == SFS_SYNC) && sync_early_r && (miss_r >= 4'(LOSS_N));
  assign ev[EV_SHUT] = run_d_r && !run;

  // Sticky status: a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= 4'h0;
      run_d_r <= 1'b0;
      irq <= 1'b0;
    end else begin
      run_d_r <= run;
      ist_r <= (ist_r & ~(clr_wr ? pwdata[EV_W-1:0] : 4'h0)) | ev;
      irq <= |(((ist_r & ~(clr_wr ? pwdata[EV_W-1:0] : 4'h0)) | ev) & ien_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      if (paddr == ADDR_CTRL) begin
        prdata <= {30'd0, bus_open_r, bus_off_r};
      end else if (paddr == ADDR_FREQ) begin
        prdata <= {21'd0, analog_r ? free_khz_r : freq_reg_r};
      end else if (paddr == ADDR_STATUS) begin
        prdata <= {26'd0, run, analog_r, sync_early_r, 1'b0, state_r};
      end else if (paddr == ADDR_IRQ_STAT) begin
        prdata <= {28'd0, ist_r};
      end else if (paddr == ADDR_IRQ_EN) begin
        prdata <= {28'd0, ien_r};
      end else if (paddr == ADDR_PERIOD) begin
        prdata <= {24'd0, per_r};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  a_fail_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SFS_FAIL) |-> !drv_high_on && !drv_low_on)
    else $error("drivers on after sync failure");
  a_enable_off: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_above_thr |-> !drv_high_on && !drv_low_on)
    else $error("drivers on while enable low");
  a_step_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    (per_r != $past(per_r)) |-> $past(wrap))
    else $error("period changed outside a cycle boundary");
  a_freq_range: assert property (@(posedge pclk) disable iff (!presetn)
    freq_reg_r >= FREQ_MIN_KHZ && freq_reg_r <= FREQ_MAX_KHZ)
    else $error("frequency register out of range");
  a_strap_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r != SFS_INIT && $past(state_r) != SFS_INIT) |-> $stable(free_khz_r))
    else $error("strap frequency changed after init");
  a_bus_shut: assert property (@(posedge pclk) disable iff (!presetn)
    bus_off_r |-> !drv_high_on && !drv_low_on)
    else $error("drivers on after bus shutdown");
  a_early_loss: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SFS_SYNC && sync_early_r && miss_r >= 4'(LOSS_N)) |=> state_r == SFS_FAIL)
    else $error("early sync loss not failed");
  a_late_loss: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SFS_SYNC && !sync_early_r && miss_r >= 4'(LOSS_N)) |=> state_r == SFS_FREE)
    else $error("late sync loss not back to free run");

  // Named steps shared by the checks below: init completion, sync loss and a
  // bus write that the mode lets through.
  sequence s_init_done;
    (state_r == SFS_INIT) && rate_strap_adc_done;
  endsequence

  sequence s_sync_lost;
    (state_r == SFS_SYNC) && (miss_r >= 4'(LOSS_N));
  endsequence

  sequence s_bus_write;
    wr && !analog_r;
  endsequence

  // Init decides once between sync-only operation and free running.
  a_init_branch: assert property (@(posedge pclk) disable iff (!presetn)
    s_init_done |=> state_r == ($past(sync_seen_r) ? SFS_SYNC : SFS_FREE))
    else $error("init did not branch on sync presence");

  a_strap_capture: assert property (@(posedge pclk) disable iff (!presetn)
    s_init_done |=> free_khz_r == sfs_strap_khz($past(rate_strap_adc[ADC_W-1 -: 4])))
    else $error("strap frequency not taken from converter code");

  a_mode_latch: assert property (@(posedge pclk) disable iff (!presetn)
    s_init_done |=> analog_r == $past(addr_strap_floating))
    else $error("mode not latched from address strap");

  // Analog mode has no bus configuration, so no write may move a register except the status bits cleared through ADDR_IRQ_CLR.
  a_analog_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && analog_r) |=> freq_reg_r == $past(freq_reg_r) && bus_off_r == $past(bus_off_r))
    else $error("register written in analog mode");

  a_freq_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_bus_write ##0 (paddr == ADDR_FREQ && wr_khz >= FREQ_MIN_KHZ && wr_khz <= FREQ_MAX_KHZ)
    |=> freq_reg_r == $past(wr_khz))
    else $error("legal frequency write not taken");

  a_bus_off_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_bus_write ##0 (paddr == ADDR_CTRL && pwdata[CTRL_OFF_BIT] && pwdata[CTRL_OPEN_BIT])
    |=> bus_off_r)
    else $error("bus shutdown request not taken");

  a_sync_enter: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SFS_FREE && sync_rise) |=> state_r == SFS_SYNC)
    else $error("late sync edge did not enter sync state");

  // A failure is final until reset; a returning clock must not restart conversion.
  a_fail_latched: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SFS_FAIL) |=> state_r == SFS_FAIL)
    else $error("failure state left without reset");

  a_fail_event: assert property (@(posedge pclk) disable iff (!presetn)
    s_sync_lost ##0 sync_early_r |=> ist_r[EV_SYNC_FAIL])
    else $error("sync failure not flagged");

  a_loss_event: assert property (@(posedge pclk) disable iff (!presetn)
    s_sync_lost |-> ev[EV_SYNC_OFF] || ev[EV_SYNC_FAIL])
    else $error("sync loss without event");

  a_miss_clear: assert property (@(posedge pclk) disable iff (!presetn)
    sync_rise |=> miss_r == 4'h0)
    else $error("miss count not cleared by sync edge");

  a_step_size: assert property (@(posedge pclk) disable iff (!presetn)
    (per_r != $past(per_r)) |->
    (per_r == $past(per_r) + STEP_CYC) || (per_r == $past(per_r) - STEP_CYC))
    else $error("period step larger than one unit");

  a_toward_ext: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SFS_SYNC && wrap && per_r < ext_per_r) |=> per_r == $past(per_r) + STEP_CYC)
    else $error("period not walking toward external clock");

  a_back_free: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SFS_FREE && wrap && per_r > free_per && per_r > 8'd2)
    |=> per_r == $past(per_r) - STEP_CYC)
    else $error("period not walking back to free run");

  a_shut_event: assert property (@(posedge pclk) disable iff (!presetn)
    (run_d_r && !run) |=> ist_r[EV_SHUT])
    else $error("conversion stop not flagged");

  // Both drivers on at once would short the supply through the bridge.
  a_drv_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    !(drv_high_on && drv_low_on))
    else $error("both drivers on together");
endmodule : sfs_top

// File: verif/sfs_sync_src.sv
/*
  Model of the external synchronization clock source on the rate/sync pin.
  Assumes the bench sets run and the half period in pclk cycles.
*/
`timescale 1ns/1ps
module sfs_sync_src (
  input wire logic pclk,
  input wire logic run,
  input wire logic [7:0] half_cyc,
  output logic rate_sync_pin
);
  logic [7:0] cnt_r;
  // A stopped source holds the pin low, so no stray edge follows removal.
  always_ff @(posedge pclk) begin
    if (!run) begin
      cnt_r <= 8'h00;
      rate_sync_pin <= 1'b0;
    end else if (cnt_r + 8'h01 >= half_cyc) begin
      cnt_r <= 8'h00;
      rate_sync_pin <= ~rate_sync_pin;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : sfs_sync_src

// File: verif/tb_sfs_top.sv
/*
  Self-checking bench for frequency selection, sync tracking and shutdown.
  Assumes a zero-wait APB slave and a 20 MHz pclk; periods are 20000/kHz cycles.
*/
`timescale 1ns/1ps
module tb_sfs_top;
  import sfs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, drv_high_on, drv_low_on, sw_clk, irq, sync_pin;
  logic floating = 1'b0, done = 1'b0, en = 1'b1, run = 1'b0;
  logic [ADC_W-1:0] adc = 10'h000;
  logic [7:0] half = 8'h14;
  logic [PER_W-1:0] ramp_slope;
  int miscompares = 0;
  int tests_run = 0;
  int khz_tab [16] = '{306, 356, 400, 444, 500, 550, 600, 706, 750, 800, 923, 1000,
                       1091, 1200, 1333, 1500};
  always #25 pclk = ~pclk;
  sfs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .addr_strap_floating(floating), .rate_strap_adc(adc),
    .rate_strap_adc_done(done), .rate_sync_pin(sync_pin), .enable_above_thr(en),
    .drv_high_on(drv_high_on), .drv_low_on(drv_low_on), .sw_clk(sw_clk),
    .ramp_slope(ramp_slope), .irq(irq));
  sfs_sync_src i_src (.pclk(pclk), .run(run), .half_cyc(half), .rate_sync_pin(sync_pin));
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
  endtask : rdc
  // Polls up to 3000 reads until the masked value matches, so convergence time is not assumed.
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, a, 32'h0000_0000);
      if ((q & m) === e) break;
    end
    chk(q & m, e);
  endtask : poll
  task automatic startup(input logic fl, input logic [ADC_W-1:0] v);
    @(posedge pclk);
    presetn <= 1'b0;
    floating <= fl;
    adc <= v;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    done <= 1'b1;
    @(posedge pclk);
    done <= 1'b0;
  endtask : startup
  initial begin
    #(60_000 * 50);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_STATUS, 32'h0000_0003, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      startup(1'b1, {i[3:0], 6'h2A});
      rdc(ADDR_FREQ, 32'h0000_FFFF, 32'(khz_tab[i]));
      rdc(ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
    end
    adc <= 10'h000;
    apb(1'b1, ADDR_FREQ, 32'h0000_00A6);
    rdc(ADDR_FREQ, 32'h0000_FFFF, 32'h0000_05DC);
    poll(ADDR_PERIOD, 32'h0000_00FF, 32'h0000_000D);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    rdc(ADDR_STATUS, 32'h0000_0020, 32'h0000_0020);
    startup(1'b0, 10'h3FF);
    rdc(ADDR_FREQ, 32'h0000_FFFF, 32'h0000_025F);
    rdc(ADDR_STATUS, 32'h0000_0013, 32'h0000_0001);
    poll(ADDR_PERIOD, 32'h0000_00FF, 32'h0000_0020);
    rdc(12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, ADDR_FREQ, 32'h0000_0064);
    rdc(ADDR_FREQ, 32'h0000_FFFF, 32'h0000_025F);
    apb(1'b1, ADDR_FREQ, 32'h0000_05DC);
    poll(ADDR_PERIOD, 32'h0000_00FF, 32'h0000_000D);
    apb(1'b1, ADDR_FREQ, 32'h0000_00A6);
    repeat (40) @(posedge pclk);
    apb(1'b0, ADDR_PERIOD, 32'h0000_0000);
    chk({31'h0, q > 32'h0000_000D && q <= 32'h0000_0014}, 32'h0000_0001);
    poll(ADDR_PERIOD, 32'h0000_00FF, 32'h0000_0078);
    apb(1'b1, ADDR_IRQ_EN, 32'h0000_0001);
    run <= 1'b1;
    poll(ADDR_STATUS, 32'h0000_0003, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    apb(1'b0, ADDR_PERIOD, 32'h0000_0000);
    chk({31'h0, q > 32'h0000_0028 && q < 32'h0000_0078}, 32'h0000_0001);
    poll(ADDR_PERIOD, 32'h0000_00FF, 32'h0000_0028);
    chk({24'h0, ramp_slope}, 32'h0000_0028);
    apb(1'b1, ADDR_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, ADDR_IRQ_CLR, 32'h0000_0001);
    rdc(ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0000);
    run <= 1'b0;
    poll(ADDR_STATUS, 32'h0000_0003, 32'h0000_0001);
    rdc(ADDR_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
    apb(1'b0, ADDR_PERIOD, 32'h0000_0000);
    chk({31'h0, q < 32'h0000_0078}, 32'h0000_0001);
    poll(ADDR_PERIOD, 32'h0000_00FF, 32'h0000_0078);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    rdc(ADDR_STATUS, 32'h0000_0020, 32'h0000_0020);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    @(posedge pclk);
    chk({30'h0, drv_high_on, drv_low_on}, 32'h0000_0000);
    rdc(ADDR_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
    startup(1'b0, 10'h000);
    repeat (100) @(posedge pclk);
    en <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({30'h0, drv_high_on, drv_low_on}, 32'h0000_0000);
    rdc(ADDR_STATUS, 32'h0000_0020, 32'h0000_0000);
    en <= 1'b1;
    // The clock is applied before init, then removed on purpose to break the hold-on duty.
    half <= 8'h0A;
    run <= 1'b1;
    repeat (30) @(posedge pclk);
    startup(1'b1, 10'h3FF);
    rdc(ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
    run <= 1'b0;
    poll(ADDR_STATUS, 32'h0000_0003, 32'h0000_0002);
    chk({30'h0, drv_high_on, drv_low_on}, 32'h0000_0000);
    rdc(ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    conclude();
  end
endmodule : tb_sfs_top
